// >>> hw/ubg_pkg.sv
// Purpose: shared constants of the baud generator and receive noise filter
// Assumes: 8-bit register port, 2-bit register index
// Notes: prescaler taps and register indexes are fixed here
package ubg_pkg;
    // register indexes on the plain register port
    localparam logic [1:0] ADDR_MODE = 2'h0;
    localparam logic [1:0] ADDR_BAUD = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam logic [1:0] ADDR_TX_LOAD = 2'h3;
    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    // serial_mode_control fields
    localparam int POWER_BIT = 7;
    localparam int TX_ENABLE_BIT = 6;
    localparam int RX_ENABLE_BIT = 5;
    localparam int PARITY_HI_BIT = 4;
    localparam int PARITY_LO_BIT = 3;
    localparam int CHAR8_BIT = 2;
    // baud_divider_control fields
    localparam int CLOCK_SELECT_HIGH = 7;
    localparam int CLOCK_SELECT_LOW = 6;
    localparam int DIVIDER_HI = 4;
    localparam int DIVIDER_LO = 0;
    // prescaler: each select value takes one tap (divide by 2, 4, 8, 16)
    localparam int PRESC_W = 8;
    localparam logic [7:0] TAP_MASK_0 = 8'h01;
    localparam logic [7:0] TAP_MASK_1 = 8'h03;
    localparam logic [7:0] TAP_MASK_2 = 8'h07;
    localparam logic [7:0] TAP_MASK_3 = 8'h0F;
    localparam int TAP_BIT_0 = 0;
    localparam int TAP_BIT_1 = 1;
    localparam int TAP_BIT_2 = 2;
    localparam int TAP_BIT_3 = 3;
    // bits after the start bit: 7 data, +1 for 8-bit, +1 parity, +1 stop
    localparam logic [3:0] BITS_BASE = 4'h8;
    // lowest supported divider value
    localparam logic [4:0] DIV_MIN = 5'h08;
    // receive sequencer states
    typedef enum logic [1:0] {
        UBG_RX_IDLE,
        UBG_RX_START_CHECK,
        UBG_RX_BITS
    } ubg_rx_state_t;
endpackage

// >>> hw/ubg_core.sv
// Purpose: receive noise filter and baud generator of the serial unit
// Assumes: rx line asynchronous to sys_clk_in; one register access a cycle
// Notes: base clock is an enable tick derived from a free prescaler
`timescale 1ns/1ns
`default_nettype none
module ubg_core (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic serial_rx_line_in,
    output logic base_clk_out,
    output logic serial_rx_filtered_out,
    output logic tx_bit_tick_out,
    output logic tx_load_out,
    output logic rx_start_out,
    output logic rx_sample_tick_out,
    output logic rx_bit_out,
    output logic rx_frame_done_out,
    output logic divider_unsupported_out
);
    ////////////////////////////////////////////////////////////////////////
    // registers and decode
    logic [7:0] mode_r; // serial_mode_control
    logic [7:0] baud_r; // baud_divider_control
    logic [7:0] rdata_r; // read data, valid one cycle after strobe
    wire wr_mode = reg_wr_in && (reg_addr_in == ubg_pkg::ADDR_MODE);
    wire wr_baud = reg_wr_in && (reg_addr_in == ubg_pkg::ADDR_BAUD);
    wire wr_tx = reg_wr_in && (reg_addr_in == ubg_pkg::ADDR_TX_LOAD);
    wire power = mode_r[ubg_pkg::POWER_BIT];
    wire tx_en = power && mode_r[ubg_pkg::TX_ENABLE_BIT];
    wire rx_en = power && mode_r[ubg_pkg::RX_ENABLE_BIT];
    wire [1:0] clk_sel = {baud_r[ubg_pkg::CLOCK_SELECT_HIGH],
                          baud_r[ubg_pkg::CLOCK_SELECT_LOW]};
    wire [4:0] div_k = baud_r[ubg_pkg::DIVIDER_HI:ubg_pkg::DIVIDER_LO];
    wire [4:0] div_last = div_k - 5'h01;
    logic [7:0] status;
    logic [7:0] rdata_nxt;

    // software writes to the mode and baud registers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            mode_r <= ubg_pkg::MODE_RESET;
            baud_r <= ubg_pkg::BAUD_RESET;
        end else begin
            if (wr_mode) begin
                mode_r <= reg_wdata_in;
            end
            if (wr_baud) begin
                baud_r <= reg_wdata_in;
            end
        end
    end

    // read mux; unmapped or write-only index reads zero
    always_comb begin
        case (reg_addr_in)
            ubg_pkg::ADDR_MODE: rdata_nxt = mode_r;
            ubg_pkg::ADDR_BAUD: rdata_nxt = baud_r;
            ubg_pkg::ADDR_STATUS: rdata_nxt = status;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd_in ? rdata_nxt : 8'h00;
        end
    end
    assign reg_rdata_out = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // prescaler and base clock
    logic [ubg_pkg::PRESC_W-1:0] presc_r; // free running prescaler
    logic base_clk_r; // visible base clock, low while powered down
    logic [7:0] tap_mask;
    logic tap_level;
    // one fixed tap per select value
    always_comb begin
        case (clk_sel)
            2'h0: begin
                tap_mask = ubg_pkg::TAP_MASK_0;
                tap_level = presc_r[ubg_pkg::TAP_BIT_0];
            end
            2'h1: begin
                tap_mask = ubg_pkg::TAP_MASK_1;
                tap_level = presc_r[ubg_pkg::TAP_BIT_1];
            end
            2'h2: begin
                tap_mask = ubg_pkg::TAP_MASK_2;
                tap_level = presc_r[ubg_pkg::TAP_BIT_2];
            end
            default: begin
                tap_mask = ubg_pkg::TAP_MASK_3;
                tap_level = presc_r[ubg_pkg::TAP_BIT_3];
            end
        endcase
    end
    // one-cycle base tick at the end of each tap period, gated by power
    wire base_tick = power && ((presc_r & tap_mask) == tap_mask);

    // prescaler runs always; the visible clock is held low without power
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            presc_r <= 8'h00;
            base_clk_r <= 1'b0;
        end else begin
            presc_r <= presc_r + 8'h01;
            base_clk_r <= power && tap_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive noise filter
    logic rx_sync1_r; // first synchroniser stage, read only by stage two
    logic rx_sync2_r;
    logic samp_a_r; // base clock samples
    logic samp_b_r;
    logic filt_r; // filtered receive level, idle high
    logic filt_d_r; // previous filtered level for edge detect
    // two-flop synchroniser for the asynchronous line
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rx_sync1_r <= 1'b1;
            rx_sync2_r <= 1'b1;
        end else begin
            rx_sync1_r <= serial_rx_line_in;
            rx_sync2_r <= rx_sync1_r;
        end
    end
    // sample per base clock; a single-sample glitch never reaches filt_r
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            samp_a_r <= 1'b1;
            samp_b_r <= 1'b1;
            filt_r <= 1'b1;
            filt_d_r <= 1'b1;
        end else if (base_tick) begin
            samp_a_r <= rx_sync2_r;
            samp_b_r <= samp_a_r;
            filt_d_r <= filt_r;
            if (samp_a_r == samp_b_r) begin
                filt_r <= samp_b_r;
            end
        end
    end
    wire rx_fall = filt_d_r && !filt_r;

    ////////////////////////////////////////////////////////////////////////
    // transmit counter: k base ticks per half bit, two halves per bit
    logic [4:0] tx_cnt_r;
    logic tx_half_r;
    logic tx_loaded_r; // set after first data write since enable
    logic tx_tick_r;
    logic tx_load_r;
    wire tx_wrap = base_tick && (tx_cnt_r == div_last);
    // hold, align to first write, or count
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !tx_en) begin
            tx_cnt_r <= 5'h00;
            tx_half_r <= 1'b0;
            tx_loaded_r <= 1'b0;
            tx_tick_r <= 1'b0;
        end else if (wr_tx && !tx_loaded_r) begin
            tx_cnt_r <= 5'h00;
            tx_half_r <= 1'b0;
            tx_loaded_r <= 1'b1;
            tx_tick_r <= 1'b0;
        end else begin
            tx_tick_r <= tx_wrap && tx_half_r;
            if (tx_wrap) begin
                tx_cnt_r <= 5'h00;
                tx_half_r <= !tx_half_r;
            end else if (base_tick) begin
                tx_cnt_r <= tx_cnt_r + 5'h01;
            end
        end
    end
    // load strobe towards the shift register, only while enabled
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tx_load_r <= 1'b0;
        end else begin
            tx_load_r <= wr_tx && tx_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive counter and sequencer
    ubg_pkg::ubg_rx_state_t rx_state_r;
    logic [4:0] rx_cnt_r;
    logic rx_half_r;
    logic [3:0] rx_bitno_r; // bits latched after the start bit
    logic rx_start_r;
    logic rx_samp_r;
    logic rx_bit_r;
    logic rx_done_r;
    wire rx_wrap = base_tick && (rx_cnt_r == div_last);
    // stop bit position: 7/8 data, optional parity, one stop
    wire [3:0] rx_last = ubg_pkg::BITS_BASE
        + {3'h0, mode_r[ubg_pkg::CHAR8_BIT]}
        + {3'h0, |mode_r[ubg_pkg::PARITY_HI_BIT:ubg_pkg::PARITY_LO_BIT]}
        - 4'h1;
    wire rx_latch = (rx_state_r == ubg_pkg::UBG_RX_BITS)
        && rx_wrap && rx_half_r;
    // start check after half a bit, then latch every full bit
    always_ff @(posedge sys_clk_in) begin
        rx_start_r <= 1'b0;
        rx_samp_r <= 1'b0;
        rx_done_r <= 1'b0;
        if (rst_in || !rx_en) begin
            rx_state_r <= ubg_pkg::UBG_RX_IDLE;
            rx_cnt_r <= 5'h00;
            rx_half_r <= 1'b0;
            rx_bitno_r <= 4'h0;
            rx_bit_r <= 1'b1;
        end else begin
            case (rx_state_r)
                ubg_pkg::UBG_RX_IDLE: begin
                    rx_cnt_r <= 5'h00;
                    rx_half_r <= 1'b0;
                    rx_bitno_r <= 4'h0;
                    if (rx_fall) begin
                        rx_state_r <= ubg_pkg::UBG_RX_START_CHECK;
                    end
                end
                ubg_pkg::UBG_RX_START_CHECK: begin
                    if (rx_wrap) begin
                        rx_cnt_r <= 5'h00;
                        if (!filt_r) begin
                            rx_state_r <= ubg_pkg::UBG_RX_BITS;
                            rx_start_r <= 1'b1;
                        end else begin
                            rx_state_r <= ubg_pkg::UBG_RX_IDLE;
                        end
                    end else if (base_tick) begin
                        rx_cnt_r <= rx_cnt_r + 5'h01;
                    end
                end
                ubg_pkg::UBG_RX_BITS: begin
                    if (rx_wrap) begin
                        rx_cnt_r <= 5'h00;
                        rx_half_r <= !rx_half_r;
                    end else if (base_tick) begin
                        rx_cnt_r <= rx_cnt_r + 5'h01;
                    end
                    if (rx_latch) begin
                        rx_samp_r <= 1'b1;
                        rx_bit_r <= filt_r;
                        rx_bitno_r <= rx_bitno_r + 4'h1;
                        if (rx_bitno_r == rx_last) begin
                            rx_done_r <= 1'b1;
                            rx_state_r <= ubg_pkg::UBG_RX_IDLE;
                        end
                    end
                end
                default: begin
                    rx_state_r <= ubg_pkg::UBG_RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status and outputs
    logic unsup_r;
    // values below the minimum give unguaranteed timing; flag them only
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            unsup_r <= 1'b0;
        end else begin
            unsup_r <= div_k < ubg_pkg::DIV_MIN;
        end
    end
    assign status = {4'h0, unsup_r, tx_loaded_r,
                     rx_state_r != ubg_pkg::UBG_RX_IDLE, filt_r};
    assign base_clk_out = base_clk_r;
    assign serial_rx_filtered_out = filt_r;
    assign tx_bit_tick_out = tx_tick_r;
    assign tx_load_out = tx_load_r;
    assign rx_start_out = rx_start_r;
    assign rx_sample_tick_out = rx_samp_r;
    assign rx_bit_out = rx_bit_r;
    assign rx_frame_done_out = rx_done_r;
    assign divider_unsupported_out = unsup_r;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_powered_off;
        !power;
    endsequence
    sequence s_start_seen;
        rx_start_r;
    endsequence
    // stop latch and done pulse share a cycle; quiet only afterwards
    sequence s_idle_quiet;
        (rx_state_r == ubg_pkg::UBG_RX_IDLE) ##1 (!rx_samp_r) [*2];
    endsequence
    property p_base_low;
        @(posedge sys_clk_in) disable iff (rst_in)
        s_powered_off |=> !base_clk_r;
    endproperty
    a_base_low: assert property (p_base_low)
        else $error("base clock not low while powered down");
    property p_filter_agree;
        @(posedge sys_clk_in) disable iff (rst_in)
        (base_tick && samp_a_r == samp_b_r) |=> (filt_r == $past(samp_b_r));
    endproperty
    a_filter_agree: assert property (p_filter_agree)
        else $error("filter ignored agreeing samples");
    property p_filter_hold;
        @(posedge sys_clk_in) disable iff (rst_in)
        (samp_a_r != samp_b_r) |=> $stable(filt_r);
    endproperty
    a_filter_hold: assert property (p_filter_hold)
        else $error("filter changed on disagreeing samples");
    property p_tx_hold;
        @(posedge sys_clk_in) disable iff (rst_in)
        !tx_en |=> (tx_cnt_r == 5'h00);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("tx counter not held at zero");
    property p_tx_align;
        @(posedge sys_clk_in) disable iff (rst_in)
        (wr_tx && !tx_loaded_r && tx_en) |=> (tx_cnt_r == 5'h00 && tx_loaded_r);
    endproperty
    a_tx_align: assert property (p_tx_align)
        else $error("tx counter not cleared by first write");
    property p_rx_hold;
        @(posedge sys_clk_in) disable iff (rst_in)
        !rx_en |=> (rx_cnt_r == 5'h00 && rx_state_r == ubg_pkg::UBG_RX_IDLE);
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("rx counter not held at zero");
    property p_rx_idle;
        @(posedge sys_clk_in) disable iff (rst_in)
        rx_done_r |-> s_idle_quiet;
    endproperty
    a_rx_idle: assert property (p_rx_idle)
        else $error("rx counter ran on after frame end");
    property p_start_low;
        @(posedge sys_clk_in) disable iff (rst_in)
        s_start_seen |-> !$past(filt_r);
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("start accepted on high line");
    property p_tick_pairs;
        @(posedge sys_clk_in) disable iff (rst_in)
        tx_tick_r |-> $past(tx_half_r);
    endproperty
    a_tick_pairs: assert property (p_tick_pairs)
        else $error("tx bit tick not on second half");
endmodule // ubg_core
`default_nettype wire

// >>> verif/ubg_remote_node.sv
// Purpose: remote serial node that sends frames onto the rx line
// Assumes: bit time given in sys clocks; the line idles high when released
// Notes: the bit time may be skewed to model a drifting remote clock
`timescale 1ns/1ns
`default_nettype none
module ubg_remote_node (
    input wire logic clk_in,
    output logic line_out
);
    // released line sits at its pull-up level
    initial line_out = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // hold one level for a number of sys clocks, changed after an edge
    task automatic bit_out(input logic v, input int c);
        @(posedge clk_in);
        line_out <= v;
        repeat (c - 1) @(posedge clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // frame: start, char bits lsb first, parity if par >= 0, one stop
    task automatic send(input logic [7:0] data, input int nbits,
        input int par, input int c);
        bit_out(1'b0, c);
        for (int i = 0; i < nbits; i++) bit_out(data[i], c);
        if (par >= 0) bit_out(par[0], c);
        bit_out(1'b1, c);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // short low pulse, used for glitches and false starts
    task automatic pulse_low(input int c);
        bit_out(1'b0, c);
        bit_out(1'b1, 1);
    endtask
endmodule // ubg_remote_node
`default_nettype wire

// >>> verif/test_uart_baud_gen_noise_filter.sv
// Purpose: self-checking bench of the baud generator and rx noise filter
// Assumes: remote node model drives the rx line; 25 MHz sys clock
// Notes: divider values come from an lfsr seeded with 61
`timescale 1ns/1ns
`default_nettype none
module test_uart_baud_gen_noise_filter;
    localparam int LIMIT = 40000; // cycles; whole run needs about 8400
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] reg_addr_in = 2'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    wire logic serial_rx_line_in; // driven by the remote node
    logic [7:0] reg_rdata_out;
    logic base_clk_out, serial_rx_filtered_out, tx_bit_tick_out, tx_load_out;
    logic rx_start_out, rx_sample_tick_out, rx_bit_out, rx_frame_done_out;
    logic divider_unsupported_out;
    logic base_prev = 1'b0, line_prev = 1'b1, filt_prev = 1'b1;
    logic [8:0] rx_bits = 9'h000; // last nine latched bits, newest on top
    int miscompares = 0;
    int checks = 0;
    int cyc = 0, tx_cnt = 0, tx_last = 0, tx_gap = 0, base_last = 0;
    int base_gap = 0, line_fall = 0, filt_lag = 0, fall_cnt = 0;
    int start_cnt = 0, done_cnt = 0, rs_last = 0, gap_bad = 0, exp_gap = 0;

    // 40 ns period
    always #20 sys_clk_in = ~sys_clk_in;

    ubg_core dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .serial_rx_line_in(serial_rx_line_in),
        .base_clk_out(base_clk_out),
        .serial_rx_filtered_out(serial_rx_filtered_out),
        .tx_bit_tick_out(tx_bit_tick_out), .tx_load_out(tx_load_out),
        .rx_start_out(rx_start_out), .rx_sample_tick_out(rx_sample_tick_out),
        .rx_bit_out(rx_bit_out), .rx_frame_done_out(rx_frame_done_out),
        .divider_unsupported_out(divider_unsupported_out));

    ubg_remote_node rt (.clk_in(sys_clk_in), .line_out(serial_rx_line_in));

    ////////////////////////////////////////////////////////////////////////
    // watchers: edge-sampled values, so no race with the design's updates
    always @(posedge sys_clk_in) begin
        cyc++;
        if (tx_bit_tick_out === 1'b1) begin
            tx_gap = cyc - tx_last;
            tx_last = cyc;
            tx_cnt++;
        end
        if (base_clk_out === 1'b1 && base_prev === 1'b0) begin
            base_gap = cyc - base_last;
            base_last = cyc;
        end
        base_prev = base_clk_out;
        if (line_prev === 1'b1 && serial_rx_line_in === 1'b0) line_fall = cyc;
        if (filt_prev === 1'b1 && serial_rx_filtered_out === 1'b0) begin
            filt_lag = cyc - line_fall;
            fall_cnt++;
        end
        line_prev = serial_rx_line_in;
        filt_prev = serial_rx_filtered_out;
        if (rx_start_out === 1'b1) begin
            start_cnt++;
            rs_last = cyc;
        end
        // every latch, first one included, sits one bit time after the last
        if (rx_sample_tick_out === 1'b1) begin
            if (cyc - rs_last != exp_gap) gap_bad++;
            rs_last = cyc;
            rx_bits = {rx_bit_out, rx_bits[8:1]};
        end
        if (rx_frame_done_out === 1'b1) done_cnt++;
        // a hang counts as a mismatch and goes to the report
        if (cyc == LIMIT) begin
            miscompares++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // sys clocks per serial bit: 2k base ticks of 2^(s+1) sys clocks
    function automatic int bit_cyc(input int s, input int k);
        return 2 * k * (2 << s);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register port master: one-cycle strobes, changed right after an edge
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask

    // bounded wait for a number of tx ticks
    task automatic wait_tx(input int n, input int lim);
        for (int i = 0; i < lim && tx_cnt < n; i++) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
        input string m);
        checks++;
        if (got !== exp) begin
            $display("[FAIL] %0t %s", $time, m);
            miscompares++;
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] lf; // lfsr state, kept apart from read data
        int k;
        int n0;
        int t0;
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        chk(divider_unsupported_out, 1'b1, "k of zero not flagged");
        rd(ubg_pkg::ADDR_MODE, d);
        chk(d, ubg_pkg::MODE_RESET, "mode reset value");
        rd(ubg_pkg::ADDR_BAUD, d);
        chk(d, ubg_pkg::BAUD_RESET, "baud reset value");
        rd(ubg_pkg::ADDR_TX_LOAD, d);
        chk(d, 8'h00, "write-only index reads nonzero");
        // enables without power: base clock low, tx counter idle
        wr(ubg_pkg::ADDR_BAUD, 8'h08);
        wr(ubg_pkg::ADDR_MODE, 8'h60);
        n0 = tx_cnt;
        repeat (200) @(posedge sys_clk_in);
        #1;
        chk(16'(base_last), 16'h0000, "base clock ran unpowered");
        chk(16'(tx_cnt - n0), 16'h0000, "tx ticks unpowered");
        wr(ubg_pkg::ADDR_MODE, 8'h80);
        repeat (200) @(posedge sys_clk_in);
        #1;
        chk(16'(tx_cnt - n0), 16'h0000, "tx ticks with tx disabled");
        // every clock select, random divider, top divider as a corner
        lf = 8'h3D;
        for (int s = 0; s < 4; s++) begin
            lf = lfsr_next(lf);
            k = (s == 3) ? 31 : 8 + lf % 24;
            wr(ubg_pkg::ADDR_MODE, 8'h00);
            wr(ubg_pkg::ADDR_BAUD, {s[1:0], 1'b0, k[4:0]});
            wr(ubg_pkg::ADDR_MODE, 8'hC0);
            wait_tx(tx_cnt + 3, 3 * bit_cyc(s, k) + 50);
            chk(16'(tx_gap), 16'(bit_cyc(s, k)), "tx bit period");
            chk(16'(base_gap), 16'(2 << s), "base clock period");
        end
        // first load mid-bit must restart the tx count
        wr(ubg_pkg::ADDR_MODE, 8'h00);
        wr(ubg_pkg::ADDR_BAUD, 8'h08);
        wr(ubg_pkg::ADDR_MODE, 8'hC0);
        wait_tx(tx_cnt + 2, 200);
        repeat (16) @(posedge sys_clk_in);
        wr(ubg_pkg::ADDR_TX_LOAD, lf);
        #1;
        chk(tx_load_out, 1'b1, "no load pulse");
        n0 = tx_cnt;
        t0 = cyc;
        wait_tx(n0 + 1, 100);
        chk(cyc - t0 >= 24 && cyc - t0 <= 40, 1'b1, "tx count kept");
        // divider below the minimum (7) and above it (16)
        wr(ubg_pkg::ADDR_BAUD, 8'h07);
        rd(ubg_pkg::ADDR_STATUS, d);
        chk(d[3], 1'b1, "status misses k below 8");
        chk(divider_unsupported_out, 1'b1, "k of 7 not flagged");
        wr(ubg_pkg::ADDR_BAUD, 8'h10);
        rd(ubg_pkg::ADDR_STATUS, d);
        chk(divider_unsupported_out, 1'b0, "k of 16 flagged");
        // receive at k 16, select 0: 64 sys clocks a bit
        exp_gap = 64;
        wr(ubg_pkg::ADDR_MODE, 8'hA4);
        n0 = fall_cnt;
        t0 = start_cnt;
        rt.pulse_low(1);
        repeat (20) @(posedge sys_clk_in);
        #1;
        chk(16'(fall_cnt - n0), 16'h0000, "glitch passed");
        rt.pulse_low(8);
        repeat (100) @(posedge sys_clk_in);
        #1;
        chk(16'(fall_cnt - n0), 16'h0001, "low level filtered out");
        chk(16'(start_cnt - t0), 16'h0000, "false start taken");
        for (int f = 0; f < 3; f++) begin
            lf = lfsr_next(lf);
            d = lf;
            wr(ubg_pkg::ADDR_MODE, f == 1 ? 8'hA8 : 8'hA4);
            n0 = start_cnt;
            t0 = done_cnt;
            // third frame comes from a remote about 3 percent fast
            rt.send(d, f == 1 ? 7 : 8, f == 1 ? int'(^d[6:0]) : -1,
                f == 2 ? 62 : 64);
            repeat (40) @(posedge sys_clk_in);
            #1;
            chk(rx_bits, f == 1 ? {1'b1, ^d[6:0], d[6:0]} : {1'b1, d},
                "rx bits");
            chk(16'(start_cnt - n0), 16'h0001, "start count");
            chk(16'(done_cnt - t0), 16'h0001, "frame end count");
            chk(filt_lag >= 3 && filt_lag <= 10, 1'b1, "filter lag");
        end
        chk(16'(gap_bad), 16'h0000, "rx latch spacing");
        // power on, receiver off: frame is ignored
        wr(ubg_pkg::ADDR_MODE, 8'h84);
        n0 = start_cnt;
        rt.send(d, 8, -1, 64);
        repeat (40) @(posedge sys_clk_in);
        #1;
        chk(16'(start_cnt - n0), 16'h0000, "rx ran while disabled");
        results();
    end
endmodule // test_uart_baud_gen_noise_filter
`default_nettype wire
